// file: ppm_fifo.sv
// small write fifo with a registered read stage
// assumes both sides on one clock; valid and ready on both sides

module ppm_fifo #(
   parameter int W = 8,  // word width
   parameter int D = 16  // depth, a power of two
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // filling side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o,
   // words held, read stage included
   output logic [$clog2(D):0] level_o
);

   localparam int AW = $clog2(D);

   // refuse depths the pointer wrap cannot serve
   if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
      $error("ppm_fifo depth must be a power of two");
   end

   // ==========================================================
   // state: storage, pointers, count and read stage
   typedef struct packed {
      logic [D-1:0][W-1:0] mem; // storage words
      logic [AW-1:0] wp;        // write pointer
      logic [AW-1:0] rp;        // read pointer
      logic [AW:0] cnt;         // words in storage
      logic ov;                 // read stage holds a word
      logic [W-1:0] od;         // read stage word
   } ppm_fifo_st_t;

   ppm_fifo_st_t s_r;
   ppm_fifo_st_t s_nxt;
   logic [AW:0] total; // storage plus read stage
   logic push;         // word accepted
   logic pop;          // read stage taken
   logic load;         // storage moves to read stage

   // next state of pointers, storage and read stage
   always_comb begin
      s_nxt = s_r;
      total = s_r.cnt + {{AW{1'b0}}, s_r.ov};
      push = in_valid_i && (total < (AW + 1)'(D));
      pop = s_r.ov && out_ready_i;
      load = (s_r.cnt != '0) && (!s_r.ov || pop);
      // store an accepted word
      if (push) begin
         s_nxt.mem[s_r.wp] = in_data_i;
         s_nxt.wp = s_r.wp + 1'b1;
      end
      // refill the read stage, or empty it
      if (load) begin
         s_nxt.od = s_r.mem[s_r.rp];
         s_nxt.rp = s_r.rp + 1'b1;
         s_nxt.ov = 1'b1;
      end else if (pop) begin
         s_nxt.ov = 1'b0;
      end
      s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
   end

   // register the state
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign in_ready_o = (total < (AW + 1)'(D));
   assign out_valid_o = s_r.ov;
   assign out_data_o = s_r.od;
   assign level_o = total;

endmodule

// file: ppm_pkg.sv
// shared constants and carrier types for the printer port block
// assumes a wishbone classic master and one 250 MHz clock domain

package ppm_pkg;

   // ==========================================================
   // sizes
   localparam int PPM_DW = 8;          // port data width
   localparam int PPM_FIFO_DEPTH = 16; // words in the write fifo
   localparam int PPM_LVL_W = 5;       // fifo level field width

   // ==========================================================
   // register byte offsets
   localparam logic [3:0] OFF_DATA = 4'h0;    // data byte
   localparam logic [3:0] OFF_STATUS = 4'h4;  // printer status
   localparam logic [3:0] OFF_CONTROL = 4'h8; // printer control
   localparam logic [3:0] OFF_FIFO = 4'hc;    // fifo level and flags

   // ==========================================================
   // status register bit positions
   localparam int ST_FAULT = 3; // fault input, low is error
   localparam int ST_PRINTER_POWERED_IN = 4;  // printer powered
   localparam int ST_PE = 5;    // paper empty
   localparam int ST_ACK = 6;   // acknowledge, low active
   localparam int ST_BUSY = 7;  // busy, read inverted

   // ==========================================================
   // control register bit positions and reset value
   localparam int CT_STROBE = 0; // 1 drives strobe low
   localparam int CT_ALF = 1;    // 1 drives auto feed low
   localparam int CT_INIT = 2;   // copied to init pin
   localparam int CT_SEL = 3;    // 1 drives select low
   localparam int CT_DIR = 5;    // 1 turns data lines to input
   localparam logic [7:0] CTRL_MASK = 8'h2f; // writable bits
   localparam logic [7:0] CTRL_RST = 8'h00;  // control after reset

   // ==========================================================
   // fifo register bit positions
   localparam int FS_EMPTY = 8; // no byte waiting
   localparam int FS_FULL = 9;  // writes to data will stall

   // ==========================================================
   // printer status pins as one bundle
   typedef struct packed {
      logic busy;    // printer busy
      logic ack_n;   // acknowledge, low active
      logic pe;      // paper empty
      logic printer_powered_in;    // printer powered
      logic fault_n; // fault, low active
   } ppm_stat_pins_t;

   // printer control pins as one bundle
   typedef struct packed {
      logic choose_n; // select printer, low active
      logic init;     // initialize, low starts it
      logic alf_n;    // auto line feed, low active
      logic strobe_n; // data strobe, low active
   } ppm_ctl_pins_t;

   localparam ppm_ctl_pins_t PINS_RST = 4'b1011; // all idle, init low

   // state of the port top
   typedef struct packed {
      logic ack;             // bus acknowledge
      logic [31:0] dat;      // bus read data
      logic [7:0] ctrl;      // control register
      logic [7:0] pd_out;    // byte on the data lines
      logic pd_oe;           // data lines driven
      logic free;            // output latch may be reloaded
      ppm_ctl_pins_t pins;   // control pin levels
   } ppm_top_st_t;

   localparam ppm_top_st_t TOP_RST = {1'b0, 32'h0000_0000, CTRL_RST,
                                      8'h00, 1'b1, 1'b1, PINS_RST};

endpackage

// file: ppm_port.sv
// printer parallel port: status inputs, control outputs, data lines
// assumes a wishbone classic master and a printer on the pins
//
// How it works
// - printer powered level read at status bit 4
// - paper empty level read at status bit 5
// - acknowledge level read at status bit 6
// - fault level read at status bit 3
// - select pin is inverse of control bit 3
// - init pin copies control bit 2
// - auto feed pin is inverse of bit 1
// - strobe pin is inverse of control bit 0
//
// The placing of the registers and register access over Wishbone are this design's own decisions.

module ppm_port
   import ppm_pkg::*;
#(
   parameter int DEPTH = ppm_pkg::PPM_FIFO_DEPTH // write fifo depth
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // printer status inputs
   input wire logic printer_powered_in_i,
   input wire logic paper_empty_in_i,
   input wire logic ack_n_i,
   input wire logic fault_n_i,
   input wire logic busy_i,
   // printer control outputs
   output logic choose_printer_n_o,
   output logic init_o,
   output logic auto_line_feed_n_o,
   output logic strobe_n_o,
   // port data lines, two-way
   input wire logic [7:0] port_data_lines_i,
   output logic [7:0] port_data_lines_o,
   output logic [7:0] port_data_lines_oe_o
);

   // refuse depths the level field cannot show
   if (DEPTH < 2 || DEPTH > 16) begin : g_chk
      $error("ppm_port depth must lie in 2 to 16");
   end

   // ==========================================================
   // pin synchronisers

   ppm_stat_pins_t stat_raw; // status pins as met
   ppm_stat_pins_t stat_s;   // status pins after two flops
   logic [7:0] pd_s;         // data lines after two flops

   // gather the status pins into one bundle
   assign stat_raw.busy = busy_i;
   assign stat_raw.ack_n = ack_n_i;
   assign stat_raw.pe = paper_empty_in_i;
   assign stat_raw.printer_powered_in = printer_powered_in_i;
   assign stat_raw.fault_n = fault_n_i;

   // all pins cross into the clock domain together
   ppm_sync #(
      .W(13)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({stat_raw, port_data_lines_i}),
      .q_o({stat_s, pd_s})
   );

   // ==========================================================
   // write fifo between the data register and the lines

   logic fifo_in_valid;       // bus offers a byte
   logic fifo_in_ready;       // fifo has room
   logic fifo_out_valid;      // a byte waits
   logic fifo_out_ready;      // latch takes a byte
   logic [7:0] fifo_out_data; // waiting byte
   logic [$clog2(DEPTH):0] fifo_level; // bytes held

   ppm_fifo #(
      .W(PPM_DW),
      .D(DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(dat_i[7:0]),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data),
      .level_o(fifo_level)
   );

   // ==========================================================
   // read data selection

   // assemble the status byte from the synchronised pins
   function automatic logic [7:0] stat_byte(input ppm_stat_pins_t p);
      logic [7:0] b;
      b = 8'h00;
      b[ST_BUSY] = !p.busy;
      b[ST_ACK] = p.ack_n;
      b[ST_PE] = p.pe;
      b[ST_PRINTER_POWERED_IN] = p.printer_powered_in;
      b[ST_FAULT] = p.fault_n;
      return b;
   endfunction

   // assemble the fifo register
   function automatic logic [31:0] fifo_word(input logic [4:0] lvl,
                                             input logic rdy,
                                             input logic vld);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[PPM_LVL_W-1:0] = lvl;
      w[FS_EMPTY] = !vld;
      w[FS_FULL] = !rdy;
      return w;
   endfunction

   // ==========================================================
   // port state

   ppm_top_st_t s_r;   // registered state
   ppm_top_st_t s_nxt; // next state
   logic req;          // new bus request
   logic wr_data;      // request writes the data byte
   logic wr_ctrl;      // request writes control
   logic [4:0] lvl5;   // fifo level at field width

   assign lvl5 = 5'(fifo_level);

   // bus, control register, output latch and pin levels
   always_comb begin
      s_nxt = s_r;
      req = cyc_i && stb_i && !s_r.ack;
      wr_data = req && we_i && (adr_i == OFF_DATA) && sel_i[0];
      wr_ctrl = req && we_i && (adr_i == OFF_CONTROL) && sel_i[0];
      fifo_in_valid = wr_data;
      fifo_out_ready = s_r.free && !s_r.ctrl[CT_DIR];
      // answer every request once; a data write waits for room
      s_nxt.ack = req && (!wr_data || fifo_in_ready);
      s_nxt.dat = 32'h0000_0000;
      // read data, zero for writes and unmapped offsets
      if (req && !we_i) begin
         case (adr_i)
            OFF_DATA: begin
               // input direction shows the lines, else the latch
               s_nxt.dat[7:0] = s_r.ctrl[CT_DIR] ? pd_s : s_r.pd_out;
            end
            OFF_STATUS: begin
               s_nxt.dat[7:0] = stat_byte(stat_s);
            end
            OFF_CONTROL: begin
               s_nxt.dat[7:0] = s_r.ctrl;
            end
            OFF_FIFO: begin
               s_nxt.dat = fifo_word(lvl5, fifo_in_ready, fifo_out_valid);
            end
            default: begin
               s_nxt.dat = 32'h0000_0000;
            end
         endcase
      end
      // control write, reserved bits stay zero
      if (wr_ctrl) begin
         s_nxt.ctrl = dat_i[7:0] & CTRL_MASK;
      end
      if (s_r.ctrl[CT_STROBE] && !s_nxt.ctrl[CT_STROBE]) begin
         s_nxt.free = 1'b1;
      end
      // load the next byte; the take wins over a release
      if (fifo_out_valid && fifo_out_ready) begin
         s_nxt.pd_out = fifo_out_data;
         s_nxt.free = 1'b0;
      end
      s_nxt.pd_oe = !s_nxt.ctrl[CT_DIR];
      s_nxt.pins.choose_n = !s_nxt.ctrl[CT_SEL];
      s_nxt.pins.init = s_nxt.ctrl[CT_INIT];
      s_nxt.pins.alf_n = !s_nxt.ctrl[CT_ALF];
      s_nxt.pins.strobe_n = !s_nxt.ctrl[CT_STROBE];
   end

   // register the state
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= TOP_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // outputs, all from flip-flops

   assign dat_o = s_r.dat;
   assign ack_o = s_r.ack;
   assign choose_printer_n_o = s_r.pins.choose_n;
   assign init_o = s_r.pins.init;
   assign auto_line_feed_n_o = s_r.pins.alf_n;
   assign strobe_n_o = s_r.pins.strobe_n;
   assign port_data_lines_o = s_r.pd_out;
   assign port_data_lines_oe_o = {8{s_r.pd_oe}};

   // ==========================================================
   // checks on the bus and pins

   a_printer_powered_in_status: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == OFF_STATUS)
      |=> (ack_o && dat_o[ST_PRINTER_POWERED_IN] == $past(stat_s.printer_powered_in)))
      else $error("powered level not in status bit 4");

   a_pe_status: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == OFF_STATUS)
      |=> dat_o[ST_PE] == $past(paper_empty_in_i, 3))
      else $error("paper empty not in status bit 5");

   a_ack_status: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ack_o && !we_i && adr_i == OFF_STATUS)
      |-> dat_o[ST_ACK] == $past(stat_s.ack_n))
      else $error("acknowledge not in status bit 6");

   a_fault_status: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ack_o && !we_i && adr_i == OFF_STATUS)
      |-> dat_o[ST_FAULT] == $past(fault_n_i, 3))
      else $error("fault not in status bit 3");

   a_busy_status: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ack_o && !we_i && adr_i == OFF_STATUS)
      |-> dat_o[ST_BUSY] != $past(busy_i, 3))
      else $error("busy not inverted in status bit 7");

   a_select_pin: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ack_o && we_i && adr_i == OFF_CONTROL && sel_i[0])
      |-> choose_printer_n_o == !dat_i[CT_SEL])
      else $error("select pin not inverse of bit 3");

   a_init_pin: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ack_o && we_i && adr_i == OFF_CONTROL && sel_i[0])
      |-> init_o == dat_i[CT_INIT])
      else $error("init pin not equal to bit 2");

   logic ctrl_bit_alf; // control bit 1 for the feed check
   assign ctrl_bit_alf = s_r.ctrl[CT_ALF];

   a_alf_pin: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $changed(auto_line_feed_n_o)
      |-> $past(wr_ctrl) && auto_line_feed_n_o != ctrl_bit_alf)
      else $error("auto feed pin not inverse of bit 1");

   a_strobe_pin: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ack_o && we_i && adr_i == OFF_CONTROL && sel_i[0])
      |-> strobe_n_o == !dat_i[CT_STROBE])
      else $error("strobe pin not inverse of bit 0");

   a_data_dir: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ack_o && we_i && adr_i == OFF_CONTROL && sel_i[0])
      |-> port_data_lines_oe_o == {8{!dat_i[CT_DIR]}})
      else $error("data direction not set by bit 5");

   a_latch_hold: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (!s_r.free && !$fell(s_r.ctrl[CT_STROBE]))
      |=> $stable(port_data_lines_o))
      else $error("data changed before strobe release");

   a_data_in_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == OFF_DATA && s_r.ctrl[CT_DIR])
      |=> dat_o[7:0] == $past(port_data_lines_i, 3))
      else $error("input lines not shown by data register");

   a_data_out_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == OFF_DATA && !s_r.ctrl[CT_DIR])
      |=> dat_o[7:0] == $past(port_data_lines_o))
      else $error("output latch not shown by data register");

   a_lines_quiet: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !port_data_lines_oe_o[0]
      |=> $stable(port_data_lines_o))
      else $error("latch reloaded while lines are inputs");

   a_select_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == OFF_CONTROL)
      |=> dat_o[CT_SEL] == !$past(choose_printer_n_o))
      else $error("select pin and control bit 3 disagree");

   a_init_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == OFF_CONTROL)
      |=> dat_o[CT_INIT] == $past(init_o))
      else $error("init pin and control bit 2 disagree");

   a_alf_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == OFF_CONTROL)
      |=> dat_o[CT_ALF] == !$past(auto_line_feed_n_o))
      else $error("auto feed pin and control bit 1 disagree");

   a_strobe_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == OFF_CONTROL)
      |=> dat_o[CT_STROBE] == !$past(strobe_n_o))
      else $error("strobe pin and control bit 0 disagree");

   a_dir_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && adr_i == OFF_CONTROL)
      |=> dat_o[CT_DIR] == !$past(port_data_lines_oe_o[0]))
      else $error("line direction and control bit 5 disagree");

endmodule

// file: ppm_printer_model.sv
// behavioural printer that stands on the pin side of the parallel port
// assumes the port's clock, plain pin levels and a bench that sets the status it wants

module ppm_printer_model
   import ppm_pkg::*;
(
   // clock
   input wire logic clk_i,
   // status levels the bench wants the printer to show
   input wire ppm_pkg::ppm_stat_pins_t want_i,
   // control pins from the port and resolved data lines
   input wire ppm_pkg::ppm_ctl_pins_t ctl_i,
   input wire logic [7:0] lines_i,
   // status pins towards the port
   output ppm_pkg::ppm_stat_pins_t stat_o,
   // captured byte, one-cycle pulse
   output logic cap_o,
   output logic [7:0] cap_data_o,
   // lines advanced by auto feed
   output logic [15:0] feed_cnt_o
);
   // ==========================================================
   // state
   logic strobe_prev = 1'b1; // strobe level at the last edge

   initial begin
      cap_o = 1'b0;
      cap_data_o = 8'h00;
      feed_cnt_o = 16'h0000;
   end

   assign stat_o = want_i;

   // ==========================================================
   // capture, line feed and initialise
   always @(posedge clk_i) begin
      strobe_prev <= ctl_i.strobe_n;
      cap_o <= 1'b0;
      // capture on strobe fall while selected
      if (strobe_prev && !ctl_i.strobe_n && !ctl_i.choose_n) begin
         cap_o <= 1'b1;
         cap_data_o <= lines_i;
         // carriage return feeds a line while auto feed low
         if (!ctl_i.alf_n && lines_i == 8'h0d) begin
            feed_cnt_o <= feed_cnt_o + 16'h0001;
         end
      end
      if (!ctl_i.init) begin
         feed_cnt_o <= 16'h0000;
      end
   end
endmodule

// file: ppm_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
// assumes the bits are independent levels, no word coherence needed

module ppm_sync #(
   parameter int W = 1 // bundle width
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // pins in, synchronised out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   // ==========================================================
   // state: first stage is read only by the second
   typedef struct packed {
      logic [W-1:0] meta; // first stage
      logic [W-1:0] q;    // second stage
   } ppm_sync_st_t;

   ppm_sync_st_t s_r;
   ppm_sync_st_t s_nxt;

   // shift the pins through both stages
   always_comb begin
      s_nxt.meta = d_i;
      s_nxt.q = s_r.meta;
   end

   // register the stages
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q_o = s_r.q;

endmodule

// file: tb_printer_port_signal_mapping.sv
// self-checking bench for the printer port: status, control pins, data path
// assumes ppm_port with a 16 word fifo and the printer model beside it

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module tb_printer_port_signal_mapping
   import ppm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // signals
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [3:0] adr_i = 4'h0, sel_i = 4'hf;
   logic [31:0] dat_i = 32'h0, dat_o, v, exp_r;
   logic ack_o, choose_printer_n_o, init_o, auto_line_feed_n_o, strobe_n_o, cap;
   logic [7:0] lines, dev_o, oe, drv = 8'h00, cap_data, exp_b;
   logic [7:0] b [17];
   logic [15:0] feed_cnt, feed_exp = 16'h0;
   ppm_stat_pins_t want = 5'h00, stat;
   int num_errors = 0, cmp_count = 0, cycles = 0;
   logic [31:0] rd_q [$];
   logic [7:0] cap_q [$];

   always #2 clk_i = ~clk_i;
   // each bit driven by the port when enabled, else by the printer
   assign lines = (oe & dev_o) | (~oe & drv);

   ppm_port u_ppm_port (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .printer_powered_in_i(stat.printer_powered_in), .paper_empty_in_i(stat.pe),
      .ack_n_i(stat.ack_n), .fault_n_i(stat.fault_n), .busy_i(stat.busy),
      .choose_printer_n_o(choose_printer_n_o), .init_o(init_o),
      .auto_line_feed_n_o(auto_line_feed_n_o), .strobe_n_o(strobe_n_o),
      .port_data_lines_i(lines), .port_data_lines_o(dev_o), .port_data_lines_oe_o(oe));

   ppm_printer_model u_ppm_printer_model (.clk_i(clk_i), .want_i(want),
      .ctl_i({choose_printer_n_o, init_o, auto_line_feed_n_o, strobe_n_o}),
      .lines_i(lines), .stat_o(stat), .cap_o(cap), .cap_data_o(cap_data),
      .feed_cnt_o(feed_cnt));

   // ==========================================================
   // bus cycles: hold the request until ack is sampled, then release
   task automatic wb_cyc(input logic [3:0] a, input logic w, input logic [31:0] d,
                         input logic [3:0] s);
      @(posedge clk_i);
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= s;
      // no limit here: only the hang guard ends a stalled wait
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      wb_cyc(a, 1'b0, 32'h0, 4'hf);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      wb_cyc(a, 1'b1, d, 4'hf);
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ==========================================================
   // watcher: read data on ack, bytes caught by the printer
   always @(posedge clk_i) begin
      if (cyc_i && !we_i && ack_o === 1'b1) begin
         exp_r = rd_q.pop_front();
         `CHK("read data", exp_r, dat_o)
      end
      if (cap === 1'b1) begin
         exp_b = cap_q.pop_front();
         `CHK("printer byte", exp_b, cap_data)
      end
   end

   // hang guard, the whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 8000) begin
         num_errors++;
         final_report();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(12356));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      `CHK("reset pins", 4'b1011, {choose_printer_n_o, init_o, auto_line_feed_n_o, strobe_n_o})
      `CHK("reset enable", 8'hff, oe)
      // status bits follow random printer levels; writes there are ignored
      wr(OFF_STATUS, 32'hffff_ffff);
      for (int i = 0; i < 10; i++) begin
         v = $urandom;
         @(posedge clk_i);
         want <= v[4:0];
         repeat (4) @(posedge clk_i);
         rd(OFF_STATUS, {24'h0, ~want.busy, want.ack_n, want.pe, want.printer_powered_in, want.fault_n, 3'h0});
      end
      // every combination of the four control bits
      for (int i = 0; i < 16; i++) begin
         v = i;
         if (v[3] && v[0]) begin
            cap_q.push_back(8'h00);
         end
         wr(OFF_CONTROL, v);
         #1;
         `CHK("select pin", ~v[3], choose_printer_n_o)
         `CHK("init pin", v[2], init_o)
         `CHK("auto feed pin", ~v[1], auto_line_feed_n_o)
         `CHK("strobe pin", ~v[0], strobe_n_o)
         rd(OFF_CONTROL, v);
      end
      // byte enable off leaves control alone, spare bits read zero
      wb_cyc(OFF_CONTROL, 1'b1, 32'hffff_ffd0, 4'he);
      rd(OFF_CONTROL, 32'h0f);
      wr(OFF_CONTROL, 32'hffff_ff50);
      rd(OFF_CONTROL, 32'h00);
      rd(4'h2, 32'h0);
      // lines turned to input read what the printer drives
      wr(OFF_CONTROL, 32'h20);
      #1;
      `CHK("input enable", 8'h00, oe)
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         drv <= 8'($urandom);
         repeat (4) @(posedge clk_i);
         rd(OFF_DATA, {24'h0, drv});
      end
      // fill the fifo until full, then drain it with strobe pulses
      wr(OFF_CONTROL, 32'h0e);
      for (int k = 0; k < 17; k++) begin
         b[k] = (k == 3) ? 8'h0d : 8'($urandom);
         wr(OFF_DATA, {24'h0, b[k]});
      end
      rd(OFF_FIFO, 32'h210);
      // output direction reads back the latch, still holding the first byte
      rd(OFF_DATA, {24'h0, b[0]});
      for (int k = 0; k < 17; k++) begin
         cap_q.push_back(b[k]);
         if (b[k] == 8'h0d) begin
            feed_exp++;
         end
         repeat (4) @(posedge clk_i);
         wr(OFF_CONTROL, 32'h0f);
         wr(OFF_CONTROL, 32'h0e);
      end
      repeat (4) @(posedge clk_i);
      rd(OFF_FIFO, 32'h100);
      repeat (2) @(posedge clk_i);
      `CHK("feed count", feed_exp, feed_cnt)
      `CHK("queues empty", 0, rd_q.size() + cap_q.size())
      final_report();
   end
endmodule
